// ---- crs_monitor.sv ----
`timescale 1ns/1ps
// port-level watcher for the register set
module crs_monitor (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic [5:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        alu_carry_valid,
   input wire logic        alu_carry,
   input wire logic [23:0] active_stack_ptr,
   input wire logic [23:0] pc_out,
   input wire logic [23:0] sbase_out,
   input wire logic [23:0] fbase_out,
   input wire logic [15:0] flags_out
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside read slot");
   a_flags_reserved: assert property ((flags_out & ~crs_pkg::FLG_IMPL_MASK) == 16'h0000)
      else $error("reserved flag bit set");
   a_carry_capture: assert property (alu_carry_valid |-> ##2 flags_out[0] == $past(alu_carry, 2))
      else $error("carry flag did not follow alu carry");
   a_unmapped_zero: assert property (reg_rd && (reg_addr inside {[6'h17:6'h1F], [6'h30:6'h3F]}
      || (reg_addr[5] && reg_addr[2:1] == 2'b11)) |=> reg_rdata == 32'h00000000)
      else $error("unmapped index read not zero");
   a_flags_view: assert property (reg_rd && reg_addr == crs_pkg::IDX_FLAGS
      |=> reg_rdata == {16'h0000, flags_out})
      else $error("flag read differs from flag view");
   a_pc_view: assert property (reg_rd && reg_addr == crs_pkg::IDX_PCNT |=> reg_rdata == {8'h00, pc_out})
      else $error("counter read differs from counter view");
   a_stack_view: assert property (reg_rd && reg_addr == crs_pkg::IDX_ACT_STACK
      |=> reg_rdata == {8'h00, active_stack_ptr})
      else $error("active stack read differs from stack view");
   a_sbase_view: assert property (reg_rd && reg_addr == crs_pkg::IDX_SBASE
      |=> reg_rdata == {8'h00, sbase_out})
      else $error("static base read differs from view");
   a_fbase_view: assert property (reg_rd && reg_addr == crs_pkg::IDX_FBASE
      |=> reg_rdata == {8'h00, fbase_out})
      else $error("frame base read differs from view");
   a_pc_saved: assert property (reg_wr && reg_addr == crs_pkg::IDX_CTRL && reg_wdata[0] ##2
      (reg_rd && reg_addr == crs_pkg::IDX_PSAVE) |=> reg_rdata == {8'h00, $past(pc_out, 2)})
      else $error("counter save does not hold old counter");
endmodule // crs_monitor

// ---- crs_pkg.sv ----
package crs_pkg;
   // register indices on the software port
   localparam logic [5:0] IDX_WORD0      = 6'h00;
   localparam logic [5:0] IDX_WORD1      = 6'h01;
   localparam logic [5:0] IDX_WORD2      = 6'h02;
   localparam logic [5:0] IDX_WORD3      = 6'h03;
   localparam logic [5:0] IDX_ADDR0      = 6'h04;
   localparam logic [5:0] IDX_ADDR1      = 6'h05;
   localparam logic [5:0] IDX_SBASE      = 6'h06;
   localparam logic [5:0] IDX_FBASE      = 6'h07;
   localparam logic [5:0] IDX_PCNT       = 6'h08;
   localparam logic [5:0] IDX_VTAB       = 6'h09;
   localparam logic [5:0] IDX_USTACK     = 6'h0A;
   localparam logic [5:0] IDX_ISTACK     = 6'h0B;
   localparam logic [5:0] IDX_FSAVE      = 6'h0C;
   localparam logic [5:0] IDX_PSAVE      = 6'h0D;
   localparam logic [5:0] IDX_FVEC       = 6'h0E;
   localparam logic [5:0] IDX_FLAGS      = 6'h0F;
   localparam logic [5:0] IDX_W0_LO      = 6'h10;
   localparam logic [5:0] IDX_W0_HI      = 6'h11;
   localparam logic [5:0] IDX_W1_LO      = 6'h12;
   localparam logic [5:0] IDX_W1_HI      = 6'h13;
   localparam logic [5:0] IDX_LONG_LO    = 6'h14;
   localparam logic [5:0] IDX_LONG_HI    = 6'h15;
   localparam logic [5:0] IDX_ACT_STACK  = 6'h16;
   localparam logic [5:0] IDX_CTRL       = 6'h17;
   // transfer channel block: base + 8*ch + field
   localparam logic [5:0] IDX_XFER_BASE  = 6'h20;
   localparam logic [2:0] XF_MODE        = 3'h0;
   localparam logic [2:0] XF_COUNT       = 3'h1;
   localparam logic [2:0] XF_CNT_RELOAD  = 3'h2;
   localparam logic [2:0] XF_MEM_ADDR    = 3'h3;
   localparam logic [2:0] XF_FIXED_ADDR  = 3'h4;
   localparam logic [2:0] XF_ADDR_RELOAD = 3'h5;
   // flag word bit positions
   localparam int FLG_CARRY  = 0;
   localparam int FLG_BANK   = 4;
   localparam int FLG_STACK  = 7;
   // implemented flag bits: 0..7 and 12..14
   localparam logic [15:0] FLG_IMPL_MASK = 16'h70FF;
   // control register bits
   localparam int CTRL_FAST_IRQ = 0;
   localparam int CTRL_RELOAD0  = 1;
   localparam int CTRL_RELOAD1  = 2;
   // reset values
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [23:0] RST_ADDR  = 24'h000000;
   localparam logic [15:0] RST_FLAGS = 16'h0000;
   localparam logic [7:0]  RST_MODE  = 8'h00;

   typedef struct packed {
      logic [15:0] word0;
      logic [15:0] word1;
      logic [15:0] word2;
      logic [15:0] word3;
      logic [23:0] addr0;
      logic [23:0] addr1;
      logic [23:0] sbase;
      logic [23:0] fbase;
   } crs_bank_s;

   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] count;
      logic [15:0] cnt_reload;
      logic [23:0] mem_addr;
      logic [23:0] fixed_addr;
      logic [23:0] addr_reload;
   } crs_xfer_s;
endpackage

// ---- crs_register_set.sv ----
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - two banks of data, address, base registers
// - four sixteen-bit general data words
// - words zero and one split into bytes
// - words pair into two 32-bit longs
// - two 24-bit address registers, full function
// - 24-bit static base for relative addressing
// - 24-bit frame base for relative addressing
// - 24-bit program counter holds next instruction
// - 24-bit vector table base register
// - two stack pointers, flag bit 7 selects
// - fast interrupt saves flag word
// - fast interrupt saves program counter
// - fast vector loads program counter
// - per-channel 8-bit transfer mode
// - per-channel 16-bit transfer count
// - count reload copied back on reload
// - per-channel 24-bit memory address
// - per-channel 24-bit fixed peripheral address
// - address reload restores memory address
// - eleven implemented flags, rest reserved
// - flag bit 0 captures carry out
// - stack flag 0 interrupt, 1 user
// - flag bit 4 selects register bank
module crs_register_set #(
   parameter int NUM_CH = 2
) (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        alu_carry_valid,
   input  wire logic        alu_carry,
   output logic      [23:0] active_stack_ptr,
   output logic      [23:0] pc_out,
   output logic      [23:0] sbase_out,
   output logic      [23:0] fbase_out,
   output logic      [15:0] flags_out
);

   crs_pkg::crs_bank_s bank_q [2];
   crs_pkg::crs_xfer_s xfer_q [NUM_CH];
   logic [23:0] pc_q, vtab_q, ustack_q, istack_q, psave_q, fvec_q;
   logic [15:0] flags_q, fsave_q;
   logic        sel;
   logic        fast_irq;
   logic [NUM_CH-1:0] reload;
   logic [2:0]  xf_field;
   logic        xf_hit;
   logic [0:0]  xf_ch;

   // merge a partial write into a wider register
   function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   assign sel      = flags_q[crs_pkg::FLG_BANK];
   assign fast_irq = reg_wr && reg_addr == crs_pkg::IDX_CTRL && reg_wdata[crs_pkg::CTRL_FAST_IRQ];
   assign xf_hit   = reg_addr[5] && reg_addr[2:0] <= crs_pkg::XF_ADDR_RELOAD && int'(reg_addr[3]) < NUM_CH
                     && !reg_addr[4];
   assign xf_ch    = reg_addr[3];
   assign xf_field = reg_addr[2:0];
   assign reload   = (reg_wr && reg_addr == crs_pkg::IDX_CTRL) ?
                     NUM_CH'(reg_wdata[crs_pkg::CTRL_RELOAD1:crs_pkg::CTRL_RELOAD0]) : '0;

   // banked registers: a write touches only the selected bank, reset clears both
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int b = 0; b < 2; b++) begin
            bank_q[b] <= '0;
         end
      end else if (reg_wr) begin
         unique case (reg_addr)
            crs_pkg::IDX_WORD0:   bank_q[sel].word0 <= reg_wdata[15:0];
            crs_pkg::IDX_WORD1:   bank_q[sel].word1 <= reg_wdata[15:0];
            crs_pkg::IDX_WORD2:   bank_q[sel].word2 <= reg_wdata[15:0];
            crs_pkg::IDX_WORD3:   bank_q[sel].word3 <= reg_wdata[15:0];
            crs_pkg::IDX_W0_LO:   bank_q[sel].word0 <= put_byte(bank_q[sel].word0, 1'b0, reg_wdata[7:0]);
            crs_pkg::IDX_W0_HI:   bank_q[sel].word0 <= put_byte(bank_q[sel].word0, 1'b1, reg_wdata[7:0]);
            crs_pkg::IDX_W1_LO:   bank_q[sel].word1 <= put_byte(bank_q[sel].word1, 1'b0, reg_wdata[7:0]);
            crs_pkg::IDX_W1_HI:   bank_q[sel].word1 <= put_byte(bank_q[sel].word1, 1'b1, reg_wdata[7:0]);
            crs_pkg::IDX_LONG_LO: begin
               bank_q[sel].word0 <= reg_wdata[15:0];
               bank_q[sel].word2 <= reg_wdata[31:16];
            end
            crs_pkg::IDX_LONG_HI: begin
               bank_q[sel].word1 <= reg_wdata[15:0];
               bank_q[sel].word3 <= reg_wdata[31:16];
            end
            crs_pkg::IDX_ADDR0:   bank_q[sel].addr0 <= reg_wdata[23:0];
            crs_pkg::IDX_ADDR1:   bank_q[sel].addr1 <= reg_wdata[23:0];
            crs_pkg::IDX_SBASE:   bank_q[sel].sbase <= reg_wdata[23:0];
            crs_pkg::IDX_FBASE:   bank_q[sel].fbase <= reg_wdata[23:0];
            default: ;
         endcase
      end
   end

   // program counter; fast interrupt jumps to the fast vector
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pc_q    <= crs_pkg::RST_ADDR;
         psave_q <= crs_pkg::RST_ADDR;
      end else if (fast_irq) begin
         psave_q <= pc_q;
         pc_q    <= fvec_q;
      end else if (reg_wr) begin
         if (reg_addr == crs_pkg::IDX_PCNT) pc_q <= reg_wdata[23:0];
         if (reg_addr == crs_pkg::IDX_PSAVE) psave_q <= reg_wdata[23:0];
      end
   end

   // flag word and its save copy; reserved bits stay zero in the flag word, the save copy takes all 16 bits
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flags_q <= crs_pkg::RST_FLAGS;
         fsave_q <= crs_pkg::RST_FLAGS;
      end else begin
         if (fast_irq) begin
            fsave_q <= flags_q;
         end else if (reg_wr && reg_addr == crs_pkg::IDX_FSAVE) begin
            fsave_q <= reg_wdata[15:0];
         end
         if (reg_wr && reg_addr == crs_pkg::IDX_FLAGS) begin
            flags_q <= reg_wdata[15:0] & crs_pkg::FLG_IMPL_MASK;
         end
         // carry from the datapath wins over a software write of the same cycle
         if (alu_carry_valid) begin
            flags_q[crs_pkg::FLG_CARRY] <= alu_carry;
         end
      end
   end

   // pointers and vectors; active stack picked by the stack flag
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         vtab_q   <= crs_pkg::RST_ADDR;
         ustack_q <= crs_pkg::RST_ADDR;
         istack_q <= crs_pkg::RST_ADDR;
         fvec_q   <= crs_pkg::RST_ADDR;
      end else if (reg_wr) begin
         unique case (reg_addr)
            crs_pkg::IDX_VTAB:      vtab_q   <= reg_wdata[23:0];
            crs_pkg::IDX_USTACK:    ustack_q <= reg_wdata[23:0];
            crs_pkg::IDX_ISTACK:    istack_q <= reg_wdata[23:0];
            crs_pkg::IDX_FVEC:      fvec_q   <= reg_wdata[23:0];
            // odd values are accepted; even ones are only faster
            crs_pkg::IDX_ACT_STACK: begin
               if (flags_q[crs_pkg::FLG_STACK]) ustack_q <= reg_wdata[23:0];
               else istack_q <= reg_wdata[23:0];
            end
            default: ;
         endcase
      end
   end

   // transfer channels with reload
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            xfer_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (reload[c]) begin
               xfer_q[c].count    <= xfer_q[c].cnt_reload;
               xfer_q[c].mem_addr <= xfer_q[c].addr_reload;
            end else if (reg_wr && xf_hit && int'(xf_ch) == c) begin
               unique case (xf_field)
                  crs_pkg::XF_MODE:        xfer_q[c].mode        <= reg_wdata[7:0];
                  crs_pkg::XF_COUNT:       xfer_q[c].count       <= reg_wdata[15:0];
                  crs_pkg::XF_CNT_RELOAD:  xfer_q[c].cnt_reload  <= reg_wdata[15:0];
                  crs_pkg::XF_MEM_ADDR:    xfer_q[c].mem_addr    <= reg_wdata[23:0];
                  crs_pkg::XF_FIXED_ADDR:  xfer_q[c].fixed_addr  <= reg_wdata[23:0];
                  crs_pkg::XF_ADDR_RELOAD: xfer_q[c].addr_reload <= reg_wdata[23:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= '0;
      end else if (!reg_rd) begin
         reg_rdata <= '0;
      end else if (xf_hit) begin
         unique case (xf_field)
            crs_pkg::XF_MODE:        reg_rdata <= {24'h000000, xfer_q[xf_ch].mode};
            crs_pkg::XF_COUNT:       reg_rdata <= {16'h0000, xfer_q[xf_ch].count};
            crs_pkg::XF_CNT_RELOAD:  reg_rdata <= {16'h0000, xfer_q[xf_ch].cnt_reload};
            crs_pkg::XF_MEM_ADDR:    reg_rdata <= {8'h00, xfer_q[xf_ch].mem_addr};
            crs_pkg::XF_FIXED_ADDR:  reg_rdata <= {8'h00, xfer_q[xf_ch].fixed_addr};
            default:                 reg_rdata <= {8'h00, xfer_q[xf_ch].addr_reload};
         endcase
      end else begin
         unique case (reg_addr)
            crs_pkg::IDX_WORD0:     reg_rdata <= {16'h0000, bank_q[sel].word0};
            crs_pkg::IDX_WORD1:     reg_rdata <= {16'h0000, bank_q[sel].word1};
            crs_pkg::IDX_WORD2:     reg_rdata <= {16'h0000, bank_q[sel].word2};
            crs_pkg::IDX_WORD3:     reg_rdata <= {16'h0000, bank_q[sel].word3};
            crs_pkg::IDX_W0_LO:     reg_rdata <= {24'h000000, bank_q[sel].word0[7:0]};
            crs_pkg::IDX_W0_HI:     reg_rdata <= {24'h000000, bank_q[sel].word0[15:8]};
            crs_pkg::IDX_W1_LO:     reg_rdata <= {24'h000000, bank_q[sel].word1[7:0]};
            crs_pkg::IDX_W1_HI:     reg_rdata <= {24'h000000, bank_q[sel].word1[15:8]};
            crs_pkg::IDX_LONG_LO:   reg_rdata <= {bank_q[sel].word2, bank_q[sel].word0};
            crs_pkg::IDX_LONG_HI:   reg_rdata <= {bank_q[sel].word3, bank_q[sel].word1};
            crs_pkg::IDX_ADDR0:     reg_rdata <= {8'h00, bank_q[sel].addr0};
            crs_pkg::IDX_ADDR1:     reg_rdata <= {8'h00, bank_q[sel].addr1};
            crs_pkg::IDX_SBASE:     reg_rdata <= {8'h00, bank_q[sel].sbase};
            crs_pkg::IDX_FBASE:     reg_rdata <= {8'h00, bank_q[sel].fbase};
            crs_pkg::IDX_PCNT:      reg_rdata <= {8'h00, pc_q};
            crs_pkg::IDX_VTAB:      reg_rdata <= {8'h00, vtab_q};
            crs_pkg::IDX_USTACK:    reg_rdata <= {8'h00, ustack_q};
            crs_pkg::IDX_ISTACK:    reg_rdata <= {8'h00, istack_q};
            crs_pkg::IDX_FSAVE:     reg_rdata <= {16'h0000, fsave_q};
            crs_pkg::IDX_PSAVE:     reg_rdata <= {8'h00, psave_q};
            crs_pkg::IDX_FVEC:      reg_rdata <= {8'h00, fvec_q};
            crs_pkg::IDX_FLAGS:     reg_rdata <= {16'h0000, flags_q};
            crs_pkg::IDX_ACT_STACK: reg_rdata <= {8'h00, flags_q[crs_pkg::FLG_STACK] ? ustack_q : istack_q};
            default:                reg_rdata <= '0;
         endcase
      end
   end

   // registered views for the addressing datapath
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         active_stack_ptr <= '0;
         pc_out           <= '0;
         sbase_out        <= '0;
         fbase_out        <= '0;
         flags_out        <= '0;
      end else begin
         active_stack_ptr <= flags_q[crs_pkg::FLG_STACK] ? ustack_q : istack_q;
         pc_out           <= pc_q;
         sbase_out        <= bank_q[sel].sbase;
         fbase_out        <= bank_q[sel].fbase;
         flags_out        <= flags_q;
      end
   end

endmodule // crs_register_set

// ---- crs_register_set_test.sv ----
`timescale 1ns/1ps
// self-checking bench for the register set
module crs_register_set_test;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic [5:0]  reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        alu_carry_valid = 1'b0;
   logic        alu_carry = 1'b0;
   logic [31:0] reg_rdata;
   logic [23:0] active_stack_ptr;
   logic [23:0] pc_out;
   logic [23:0] sbase_out;
   logic [23:0] fbase_out;
   logic [15:0] flags_out;
   int          n_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;

   crs_register_set #(.NUM_CH(2)) crs_register_set_inst (.ref_clk(ref_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .alu_carry_valid(alu_carry_valid), .alu_carry(alu_carry),
      .active_stack_ptr(active_stack_ptr), .pc_out(pc_out), .sbase_out(sbase_out),
      .fbase_out(fbase_out), .flags_out(flags_out));

   // 100 MHz clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, exp, reg_rdata);
   endtask

   task automatic carry(input logic v);
      @(posedge ref_clk);
      alu_carry_valid <= 1'b1;
      alu_carry <= v;
      @(posedge ref_clk);
      alu_carry_valid <= 1'b0;
   endtask

   task automatic t_bank;
      wr(crs_pkg::IDX_WORD0, 32'h00001111);
      wr(crs_pkg::IDX_SBASE, 32'h00AAAAAA);
      wr(crs_pkg::IDX_FBASE, 32'h00333333);
      wr(crs_pkg::IDX_FLAGS, 32'h00000010);
      rd(crs_pkg::IDX_WORD0, 32'h00000000, "bank1 word0");
      wr(crs_pkg::IDX_WORD0, 32'h00002222);
      wr(crs_pkg::IDX_SBASE, 32'h00555555);
      rd(crs_pkg::IDX_SBASE, 32'h00555555, "bank1 sbase");
      wr(crs_pkg::IDX_FLAGS, 32'h00000000);
      rd(crs_pkg::IDX_WORD0, 32'h00001111, "bank0 word0");
      rd(crs_pkg::IDX_SBASE, 32'h00AAAAAA, "bank0 sbase");
      chk("static base view", 32'h00AAAAAA, {8'h00, sbase_out});
      chk("frame base view", 32'h00333333, {8'h00, fbase_out});
   endtask

   task automatic t_views;
      wr(crs_pkg::IDX_WORD0, 32'h00001234);
      wr(crs_pkg::IDX_W0_HI, 32'h000000AB);
      rd(crs_pkg::IDX_WORD0, 32'h0000AB34, "high byte merge");
      wr(crs_pkg::IDX_WORD1, 32'h00005678);
      wr(crs_pkg::IDX_W1_LO, 32'h000000CD);
      rd(crs_pkg::IDX_W1_HI, 32'h00000056, "word1 high byte");
      wr(crs_pkg::IDX_W1_HI, 32'hFFFFFF9A);
      rd(crs_pkg::IDX_WORD1, 32'h00009ACD, "word1 both bytes");
      wr(crs_pkg::IDX_W0_LO, 32'hFFFFFF77);
      rd(crs_pkg::IDX_WORD0, 32'h0000AB77, "low byte merge");
      wr(crs_pkg::IDX_LONG_LO, 32'h89ABCDEF);
      rd(crs_pkg::IDX_WORD2, 32'h000089AB, "long low upper");
      rd(crs_pkg::IDX_W0_LO, 32'h000000EF, "long low lower");
      wr(crs_pkg::IDX_LONG_HI, 32'h01234567);
      rd(crs_pkg::IDX_WORD3, 32'h00000123, "long high upper");
      rd(crs_pkg::IDX_WORD1, 32'h00004567, "long high lower");
   endtask

   // all-ones written to indices 0 to 15 (stack pointers get FFFFFFFE) and to every channel field, width shows in what comes back
   task automatic t_widths;
      logic [31:0] m;
      logic [31:0] d;
      for (int i = 0; i < 16; i++) begin
         m = (i < 4 || i == 12) ? 32'h0000FFFF : (i == 15 ? 32'h000070FF : 32'h00FFFFFF);
         // stack pointers only ever get even values from software
         d = (i == 10 || i == 11) ? 32'hFFFFFFFE : 32'hFFFFFFFF;
         wr(6'(i), d);
         rd(6'(i), m & d, "core width");
      end
      for (int c = 0; c < 2; c++) begin
         for (int f = 0; f < 6; f++) begin
            m = (f == 0) ? 32'h000000FF : (f < 3 ? 32'h0000FFFF : 32'h00FFFFFF);
            wr(6'(32 + 8 * c + f), 32'hFFFFFFFF);
            rd(6'(32 + 8 * c + f), m, "channel width");
         end
      end
      wr(crs_pkg::IDX_FLAGS, 32'h00000000);
   endtask

   task automatic t_stack;
      wr(crs_pkg::IDX_USTACK, 32'h00000100);
      wr(crs_pkg::IDX_ISTACK, 32'h00000200);
      rd(crs_pkg::IDX_ACT_STACK, 32'h00000200, "stack flag 0");
      wr(crs_pkg::IDX_FLAGS, 32'h00000080);
      rd(crs_pkg::IDX_ACT_STACK, 32'h00000100, "stack flag 1");
      wr(crs_pkg::IDX_ACT_STACK, 32'h00000300);
      rd(crs_pkg::IDX_USTACK, 32'h00000300, "user stack write");
      chk("active stack view", 32'h00000300, {8'h00, active_stack_ptr});
      rd(crs_pkg::IDX_ISTACK, 32'h00000200, "int stack kept");
      wr(crs_pkg::IDX_FLAGS, 32'h00000000);
      wr(crs_pkg::IDX_ACT_STACK, 32'h00000400);
      rd(crs_pkg::IDX_ISTACK, 32'h00000400, "int stack write");
   endtask

   task automatic t_fast;
      carry(1'b1);
      rd(crs_pkg::IDX_FLAGS, 32'h00000001, "carry set");
      wr(crs_pkg::IDX_PCNT, 32'h00123456);
      wr(crs_pkg::IDX_FVEC, 32'h000ABCDE);
      wr(crs_pkg::IDX_FLAGS, 32'h000050C1);
      wr(crs_pkg::IDX_CTRL, 32'h00000001);
      rd(crs_pkg::IDX_PSAVE, 32'h00123456, "counter save");
      rd(crs_pkg::IDX_FSAVE, 32'h000050C1, "flag save");
      rd(crs_pkg::IDX_PCNT, 32'h000ABCDE, "fast vector jump");
      chk("counter view", 32'h000ABCDE, {8'h00, pc_out});
      carry(1'b0);
      rd(crs_pkg::IDX_FLAGS, 32'h000050C0, "carry clear");
      chk("flag view", 32'h000050C0, {16'h0000, flags_out});
      wr(crs_pkg::IDX_FLAGS, 32'h00000000);
   endtask

   task automatic t_reload;
      logic [5:0] b;
      for (int c = 0; c < 2; c++) begin
         b = 6'(32 + 8 * c);
         wr(b + 6'h01, 32'h00000005);
         wr(b + 6'h02, 32'h000000F0);
         wr(b + 6'h03, 32'h00001000);
         wr(b + 6'h05, 32'h00002000);
         wr(crs_pkg::IDX_CTRL, 32'(2 << c));
         rd(b + 6'h01, 32'h000000F0, "count reload");
         rd(b + 6'h03, 32'h00002000, "address reload");
         rd(b + 6'h04, 32'h00FFFFFF, "fixed address kept");
      end
   endtask

   // mid-run reset clears what earlier scenarios left behind
   task automatic t_reset;
      @(posedge ref_clk);
      srst <= 1'b1;
      @(posedge ref_clk);
      srst <= 1'b0;
      rd(crs_pkg::IDX_XFER_BASE + 6'h04, 32'h00000000, "fixed address reset");
      rd(crs_pkg::IDX_USTACK, 32'h00000000, "user stack reset");
      chk("counter view reset", 32'h00000000, {8'h00, pc_out});
   endtask

   task automatic t_unmapped;
      wr(6'h3F, 32'hFFFFFFFF);
      rd(6'h3F, 32'h00000000, "unmapped top");
      rd(6'h26, 32'h00000000, "channel field 6");
      rd(crs_pkg::IDX_CTRL, 32'h00000000, "control reads");
      rd(6'h18, 32'h00000000, "unmapped gap");
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      rd(crs_pkg::IDX_PCNT, 32'h00000000, "counter reset");
      t_bank();
      t_views();
      t_widths();
      t_stack();
      t_fast();
      t_reload();
      t_reset();
      t_unmapped();
      close_out();
   end
endmodule // crs_register_set_test

bind crs_register_set crs_monitor crs_monitor_inst (.ref_clk(ref_clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .alu_carry_valid(alu_carry_valid), .alu_carry(alu_carry),
   .active_stack_ptr(active_stack_ptr), .pc_out(pc_out), .sbase_out(sbase_out),
   .fbase_out(fbase_out), .flags_out(flags_out));
